// ### rtl/cpu_ops_pkg.sv
/*
  Shared constants and types for the trap, wait, test and stack transfer
  execution block. Assumes one CPU clock and a byte-wide memory port.
*/
package cpu_ops_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Opcodes
  localparam logic [7:0] OPC_TRAP = 8'h83;
  localparam logic [7:0] OPC_WAIT = 8'h8F;
  localparam logic [7:0] OPC_TEST_DIR = 8'h3D;
  localparam logic [7:0] OPC_TEST_A = 8'h4D;
  localparam logic [7:0] OPC_TEST_X = 8'h5D;
  localparam logic [7:0] OPC_TEST_IXB = 8'h6D;
  localparam logic [7:0] OPC_TEST_IX = 8'h7D;
  localparam logic [7:0] OPC_PREFIX_SP = 8'h9E;
  localparam logic [7:0] OPC_STACK_TO_INDEX = 8'h95;
  localparam logic [7:0] OPC_INDEX_TO_STACK = 8'h94;

  ////////////////////////////////////////////////////////////////////////////
  // Cycle counts
  localparam logic [3:0] CYC_TRAP = 4'h9;
  localparam logic [3:0] CYC_WAIT = 4'h1;
  localparam logic [3:0] CYC_TEST_REG = 4'h1;
  localparam logic [3:0] CYC_TEST_DIR = 4'h3;
  localparam logic [3:0] CYC_TEST_IXB = 4'h3;
  localparam logic [3:0] CYC_TEST_IX = 4'h2;
  localparam logic [3:0] CYC_TEST_SPB = 4'h4;
  localparam logic [3:0] CYC_XFER = 4'h2;

  // Step numbers within an instruction
  localparam logic [3:0] STEP_FIRST = 4'h0;
  localparam logic [3:0] STEP_TEST_FLAG = 4'h1;
  localparam logic [3:0] STEP_XFER = 4'h1;
  localparam logic [3:0] STEP_PUSH_PC_LO = 4'h1;
  localparam logic [3:0] STEP_PUSH_PC_HI = 4'h2;
  localparam logic [3:0] STEP_PUSH_X = 4'h3;
  localparam logic [3:0] STEP_PUSH_A = 4'h4;
  localparam logic [3:0] STEP_PUSH_FLAGS = 4'h5;
  localparam logic [3:0] STEP_VEC_HI = 4'h6;
  localparam logic [3:0] STEP_VEC_LO = 4'h7;
  localparam logic [3:0] STEP_VEC_DONE = 4'h8;
  localparam logic [3:0] STEP_ONE = 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Condition flag bit positions
  localparam int FLAG_V = 7;
  localparam int FLAG_I = 3;
  localparam int FLAG_N = 2;
  localparam int FLAG_Z = 1;
  localparam int SIGN_BIT = 7;

  // Reset values and vector
  localparam logic [15:0] RST_PC = 16'h0000;
  localparam logic [15:0] RST_SP = 16'h00FF;
  localparam logic [15:0] RST_HX = 16'h0000;
  localparam logic [7:0] RST_A = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h68;
  localparam logic [15:0] TRAP_VECTOR_DEFAULT = 16'hFFFC;
  localparam logic [15:0] ONE16 = 16'h0001;
  localparam logic [7:0] ZERO8 = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [3:0] {
    K_NONE, K_TRAP, K_WAIT, K_TEST_A, K_TEST_X, K_TEST_DIR, K_TEST_IXB,
    K_TEST_IX, K_TEST_SPB, K_S2I, K_I2S
  } kind_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_SLEEP = 3'b100
  } state_t;

  typedef struct packed {
    logic prefix;
    logic [7:0] opcode;
    logic [7:0] operand;
  } op_req_t;

  typedef struct packed {
    logic re;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [15:0] sp;
    logic [15:0] hx;
    logic [7:0] a;
    logic [7:0] flags;
  } cpu_regs_t;

endpackage

// ### rtl/cpu_trap_wait_test_ops.sv
/*
  Execution unit for software trap, wait, zero/sign test and stack/index
  transfers, holding the core's programmer-visible registers.
  Assumes memory reads return data the cycle after mem.re, writes take
  effect at the edge, and an outside fetch stage supplies decoded bytes.
*/
`timescale 1ns/1ns
module cpu_trap_wait_test_ops #(
  parameter logic [15:0] TRAP_VECTOR = cpu_ops_pkg::TRAP_VECTOR_DEFAULT
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Instruction issue
  input wire logic issue_valid,
  input wire cpu_ops_pkg::op_req_t issue_req,
  output logic issue_ready,
  output logic done,
  output logic illegal,
  // Memory port
  output cpu_ops_pkg::mem_req_t mem,
  input wire logic [7:0] mem_rdata,
  // Wake and clock control
  input wire logic irq,
  output logic core_clk_stop,
  // Register view
  output cpu_ops_pkg::cpu_regs_t regs
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_meta_ff;
  logic rst_n_ff;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Functions
  function automatic cpu_ops_pkg::kind_t decode(input cpu_ops_pkg::op_req_t r);
    cpu_ops_pkg::kind_t k;
    k = cpu_ops_pkg::K_NONE;
    if (r.prefix) begin
      if (r.opcode == cpu_ops_pkg::OPC_TEST_IXB) begin
        k = cpu_ops_pkg::K_TEST_SPB;
      end
    end else begin
      unique case (r.opcode)
        cpu_ops_pkg::OPC_TRAP: k = cpu_ops_pkg::K_TRAP;
        cpu_ops_pkg::OPC_WAIT: k = cpu_ops_pkg::K_WAIT;
        cpu_ops_pkg::OPC_TEST_DIR: k = cpu_ops_pkg::K_TEST_DIR;
        cpu_ops_pkg::OPC_TEST_A: k = cpu_ops_pkg::K_TEST_A;
        cpu_ops_pkg::OPC_TEST_X: k = cpu_ops_pkg::K_TEST_X;
        cpu_ops_pkg::OPC_TEST_IXB: k = cpu_ops_pkg::K_TEST_IXB;
        cpu_ops_pkg::OPC_TEST_IX: k = cpu_ops_pkg::K_TEST_IX;
        cpu_ops_pkg::OPC_STACK_TO_INDEX: k = cpu_ops_pkg::K_S2I;
        cpu_ops_pkg::OPC_INDEX_TO_STACK: k = cpu_ops_pkg::K_I2S;
        default: k = cpu_ops_pkg::K_NONE;
      endcase
    end
    return k;
  endfunction

  function automatic logic [3:0] cycles_of(input cpu_ops_pkg::kind_t k);
    logic [3:0] c;
    c = cpu_ops_pkg::CYC_TEST_REG;
    unique case (k)
      cpu_ops_pkg::K_TRAP: c = cpu_ops_pkg::CYC_TRAP;
      cpu_ops_pkg::K_WAIT: c = cpu_ops_pkg::CYC_WAIT;
      cpu_ops_pkg::K_TEST_DIR: c = cpu_ops_pkg::CYC_TEST_DIR;
      cpu_ops_pkg::K_TEST_IXB: c = cpu_ops_pkg::CYC_TEST_IXB;
      cpu_ops_pkg::K_TEST_IX: c = cpu_ops_pkg::CYC_TEST_IX;
      cpu_ops_pkg::K_TEST_SPB: c = cpu_ops_pkg::CYC_TEST_SPB;
      cpu_ops_pkg::K_S2I, cpu_ops_pkg::K_I2S: c = cpu_ops_pkg::CYC_XFER;
      default: c = cpu_ops_pkg::CYC_TEST_REG;
    endcase
    return c;
  endfunction

  // Operand minus zero: nothing stored, only V, N and Z change
  function automatic logic [7:0] test_flags(input logic [7:0] flags_in, input logic [7:0] val);
    logic [7:0] f;
    logic [7:0] diff;
    f = flags_in;
    diff = val - cpu_ops_pkg::ZERO8;
    f[cpu_ops_pkg::FLAG_V] = 1'b0;
    f[cpu_ops_pkg::FLAG_N] = diff[cpu_ops_pkg::SIGN_BIT];
    f[cpu_ops_pkg::FLAG_Z] = (diff == cpu_ops_pkg::ZERO8);
    return f;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  cpu_ops_pkg::state_t state_ff;
  cpu_ops_pkg::kind_t kind_ff;
  logic [7:0] operand_ff;
  logic [3:0] step_ff;
  logic [3:0] last_ff;
  logic [7:0] vec_hi_ff;
  cpu_ops_pkg::kind_t nxt_kind;
  logic accept;
  logic last_step;

  assign nxt_kind = decode(issue_req);
  assign issue_ready = (state_ff == cpu_ops_pkg::ST_IDLE);
  assign accept = issue_valid && issue_ready && (nxt_kind != cpu_ops_pkg::K_NONE);
  assign illegal = issue_valid && issue_ready && (nxt_kind == cpu_ops_pkg::K_NONE);
  assign last_step = (state_ff == cpu_ops_pkg::ST_EXEC) && (step_ff == last_ff);
  assign done = last_step;
  // The core's own clock is held while asleep; irq or reset restarts it
  assign core_clk_stop = (state_ff == cpu_ops_pkg::ST_SLEEP);

  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff <= cpu_ops_pkg::ST_IDLE;
    end else begin
      unique case (state_ff)
        cpu_ops_pkg::ST_IDLE: begin
          if (accept) begin
            state_ff <= cpu_ops_pkg::ST_EXEC;
          end
        end
        cpu_ops_pkg::ST_EXEC: begin
          if (last_step) begin
            state_ff <= (kind_ff == cpu_ops_pkg::K_WAIT) ? cpu_ops_pkg::ST_SLEEP
                                                         : cpu_ops_pkg::ST_IDLE;
          end
        end
        cpu_ops_pkg::ST_SLEEP: begin
          if (irq) begin
            state_ff <= cpu_ops_pkg::ST_IDLE;
          end
        end
        default: state_ff <= cpu_ops_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      kind_ff <= cpu_ops_pkg::K_NONE;
      operand_ff <= cpu_ops_pkg::ZERO8;
      last_ff <= cpu_ops_pkg::STEP_FIRST;
      step_ff <= cpu_ops_pkg::STEP_FIRST;
    end else if (accept) begin
      kind_ff <= nxt_kind;
      operand_ff <= issue_req.operand;
      last_ff <= cycles_of(nxt_kind) - cpu_ops_pkg::STEP_ONE;
      step_ff <= cpu_ops_pkg::STEP_FIRST;
    end else if (state_ff == cpu_ops_pkg::ST_EXEC) begin
      step_ff <= step_ff + cpu_ops_pkg::STEP_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory requests
  logic exec;
  assign exec = (state_ff == cpu_ops_pkg::ST_EXEC);

  always_comb begin
    mem = '0;
    if (exec) begin
      unique case (kind_ff)
        cpu_ops_pkg::K_TEST_DIR: begin
          mem.re = (step_ff == cpu_ops_pkg::STEP_FIRST);
          mem.addr = {cpu_ops_pkg::ZERO8, operand_ff};
        end
        cpu_ops_pkg::K_TEST_IXB: begin
          mem.re = (step_ff == cpu_ops_pkg::STEP_FIRST);
          mem.addr = regs.hx + {cpu_ops_pkg::ZERO8, operand_ff};
        end
        cpu_ops_pkg::K_TEST_IX: begin
          mem.re = (step_ff == cpu_ops_pkg::STEP_FIRST);
          mem.addr = regs.hx;
        end
        cpu_ops_pkg::K_TEST_SPB: begin
          mem.re = (step_ff == cpu_ops_pkg::STEP_FIRST);
          mem.addr = regs.sp + {cpu_ops_pkg::ZERO8, operand_ff};
        end
        cpu_ops_pkg::K_TRAP: begin
          mem.addr = regs.sp;
          unique case (step_ff)
            cpu_ops_pkg::STEP_PUSH_PC_LO: begin
              mem.we = 1'b1;
              mem.wdata = regs.pc[7:0];
            end
            cpu_ops_pkg::STEP_PUSH_PC_HI: begin
              mem.we = 1'b1;
              mem.wdata = regs.pc[15:8];
            end
            cpu_ops_pkg::STEP_PUSH_X: begin
              mem.we = 1'b1;
              mem.wdata = regs.hx[7:0];
            end
            cpu_ops_pkg::STEP_PUSH_A: begin
              mem.we = 1'b1;
              mem.wdata = regs.a;
            end
            cpu_ops_pkg::STEP_PUSH_FLAGS: begin
              mem.we = 1'b1;
              mem.wdata = regs.flags;
            end
            cpu_ops_pkg::STEP_VEC_HI: begin
              mem.re = 1'b1;
              mem.addr = TRAP_VECTOR;
            end
            cpu_ops_pkg::STEP_VEC_LO: begin
              mem.re = 1'b1;
              mem.addr = TRAP_VECTOR + cpu_ops_pkg::ONE16;
            end
            default: mem.addr = regs.sp;
          endcase
        end
        default: mem = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register updates
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      vec_hi_ff <= cpu_ops_pkg::ZERO8;
    end else if (kind_ff == cpu_ops_pkg::K_TRAP && step_ff == cpu_ops_pkg::STEP_VEC_LO) begin
      // Step seven of a trap only exists while executing, so no state term is needed
      vec_hi_ff <= mem_rdata;
    end
  end

  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      regs.pc <= cpu_ops_pkg::RST_PC;
      regs.sp <= cpu_ops_pkg::RST_SP;
      regs.hx <= cpu_ops_pkg::RST_HX;
      regs.a <= cpu_ops_pkg::RST_A;
      regs.flags <= cpu_ops_pkg::RST_FLAGS;
    end else if (exec) begin
      unique case (kind_ff)
        cpu_ops_pkg::K_WAIT: regs.flags[cpu_ops_pkg::FLAG_I] <= 1'b0;
        cpu_ops_pkg::K_TEST_A: regs.flags <= test_flags(regs.flags, regs.a);
        cpu_ops_pkg::K_TEST_X: regs.flags <= test_flags(regs.flags, regs.hx[7:0]);
        cpu_ops_pkg::K_TEST_DIR, cpu_ops_pkg::K_TEST_IXB, cpu_ops_pkg::K_TEST_IX,
        cpu_ops_pkg::K_TEST_SPB: begin
          if (step_ff == cpu_ops_pkg::STEP_TEST_FLAG) begin
            regs.flags <= test_flags(regs.flags, mem_rdata);
          end
        end
        cpu_ops_pkg::K_S2I: begin
          if (step_ff == cpu_ops_pkg::STEP_XFER) begin
            regs.hx <= regs.sp + cpu_ops_pkg::ONE16;
          end
        end
        cpu_ops_pkg::K_I2S: begin
          if (step_ff == cpu_ops_pkg::STEP_XFER) begin
            regs.sp <= regs.hx - cpu_ops_pkg::ONE16;
          end
        end
        cpu_ops_pkg::K_TRAP: begin
          if (step_ff == cpu_ops_pkg::STEP_FIRST) begin
            regs.pc <= regs.pc + cpu_ops_pkg::ONE16;
          end
          if (step_ff inside {[cpu_ops_pkg::STEP_PUSH_PC_LO:cpu_ops_pkg::STEP_PUSH_FLAGS]}) begin
            regs.sp <= regs.sp - cpu_ops_pkg::ONE16;
          end
          if (step_ff == cpu_ops_pkg::STEP_VEC_HI) begin
            regs.flags[cpu_ops_pkg::FLAG_I] <= 1'b1;
          end
          if (step_ff == cpu_ops_pkg::STEP_VEC_DONE) begin
            regs.pc <= {vec_hi_ff, mem_rdata};
          end
        end
        default: regs.flags <= regs.flags;
      endcase
    end
  end

endmodule

// ### test/cpu_ops_checker.sv
/*
  Port-level assertions for the trap/wait/test execution unit.
  Assumes one clock domain and sees only the unit's top-level ports.
*/
`timescale 1ns/1ns
module cpu_ops_checker #(
  parameter logic [15:0] TRAP_VECTOR = cpu_ops_pkg::TRAP_VECTOR_DEFAULT
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Issue
  input wire logic issue_valid,
  input wire cpu_ops_pkg::op_req_t issue_req,
  input wire logic issue_ready,
  input wire logic done,
  input wire logic illegal,
  // Memory, wake and register view
  input wire cpu_ops_pkg::mem_req_t mem,
  input wire logic [7:0] mem_rdata,
  input wire logic irq,
  input wire logic core_clk_stop,
  input wire cpu_ops_pkg::cpu_regs_t regs
);
  logic take;
  assign take = issue_valid && issue_ready && !illegal;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_take(logic pfx, logic [7:0] op);
    take && issue_req.prefix == pfx && issue_req.opcode == op;
  endsequence
  sequence s_vec_fetch;
    mem.re && mem.addr == TRAP_VECTOR ##1 mem.re && mem.addr == TRAP_VECTOR + 16'h0001;
  endsequence
  property p_trap_len;
    s_take(1'b0, cpu_ops_pkg::OPC_TRAP) |=> !done [*8] ##1 done;
  endproperty
  a_trap_len: assert property (p_trap_len) else $error("trap length");
  property p_trap_vec;
    s_take(1'b0, cpu_ops_pkg::OPC_TRAP) |-> ##7 s_vec_fetch ##1 regs.flags[3];
  endproperty
  a_trap_vec: assert property (p_trap_vec) else $error("trap vector");
  property p_trap_first;
    s_take(1'b0, cpu_ops_pkg::OPC_TRAP) |-> ##2 (regs.pc == $past(regs.pc, 2) + 16'h0001
      && mem.we && mem.wdata == regs.pc[7:0] && mem.addr == regs.sp);
  endproperty
  a_trap_first: assert property (p_trap_first) else $error("trap first push");
  property p_push_step;
    mem.we ##1 mem.we |-> mem.addr == $past(mem.addr) - 16'h0001;
  endproperty
  a_push_step: assert property (p_push_step) else $error("push address step");
  property p_wait;
    s_take(1'b0, cpu_ops_pkg::OPC_WAIT) |=> done ##1 (!regs.flags[3] && (core_clk_stop || irq));
  endproperty
  a_wait: assert property (p_wait) else $error("wait step");
  property p_sleep;
    core_clk_stop && !irq |=> core_clk_stop && !done && !issue_ready;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep left early");
  property p_test_acc;
    s_take(1'b0, cpu_ops_pkg::OPC_TEST_A) |=> done ##1
      (!regs.flags[7] && regs.flags[2] == regs.a[7] && regs.flags[1] == (regs.a == 8'h00));
  endproperty
  a_test_acc: assert property (p_test_acc) else $error("test flags");
  property p_test_ix;
    s_take(1'b0, cpu_ops_pkg::OPC_TEST_IX) |=> mem.re && mem.addr == regs.hx && !done ##1 done;
  endproperty
  a_test_ix: assert property (p_test_ix) else $error("test indexed");
  property p_test_sp;
    s_take(1'b1, cpu_ops_pkg::OPC_TEST_IXB) |=> !done [*3] ##1 done;
  endproperty
  a_test_sp: assert property (p_test_sp) else $error("test stack offset");
  property p_s2i;
    s_take(1'b0, cpu_ops_pkg::OPC_STACK_TO_INDEX) |=> !done ##1 done ##1
      (regs.hx == regs.sp + 16'h0001 && $stable(regs.flags));
  endproperty
  a_s2i: assert property (p_s2i) else $error("stack to index");
endmodule

bind cpu_trap_wait_test_ops cpu_ops_checker #(.TRAP_VECTOR(TRAP_VECTOR)) u_checker (
  .clock(clock), .arst_n(arst_n), .issue_valid(issue_valid), .issue_req(issue_req),
  .issue_ready(issue_ready), .done(done), .illegal(illegal), .mem(mem),
  .mem_rdata(mem_rdata), .irq(irq), .core_clk_stop(core_clk_stop), .regs(regs));

// ### test/test_cpu_trap_wait_test_ops.sv
/*
  Self-checking bench for the trap/wait/test execution unit.
  Drives issue and memory ports directly; memory is a byte function.
*/
`timescale 1ns/1ns
module test_cpu_trap_wait_test_ops;
  // Vector value is arbitrary
  localparam logic [15:0] VEC = 16'h1230;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic issue_valid = 1'b0;
  logic irq = 1'b0;
  logic [7:0] mem_rdata = 8'h00;
  cpu_ops_pkg::op_req_t issue_req = '0;
  logic issue_ready, done, illegal, core_clk_stop;
  cpu_ops_pkg::mem_req_t mem;
  cpu_ops_pkg::cpu_regs_t regs, r0;
  int fails = 0;
  int cmp_count = 0;
  int ticks = 0;
  logic [7:0] rd_val, vec_hi, vec_lo;
  logic [15:0] rd_addr;
  logic [7:0] wq[$];
  logic [15:0] aq[$];
  logic [7:0] tops[6] = '{8'h3D, 8'h4D, 8'h5D, 8'h6D, 8'h7D, 8'h6D};
  int tcyc[6] = '{3, 1, 1, 3, 2, 4};
  cpu_ops_pkg::op_req_t bad[2] = '{'{1'b1, 8'h4D, 8'h00}, '{1'b0, 8'h42, 8'h00}};

  always #25 clock = ~clock;

  cpu_trap_wait_test_ops #(.TRAP_VECTOR(VEC)) dut (.clock(clock), .arst_n(arst_n),
    .issue_valid(issue_valid), .issue_req(issue_req), .issue_ready(issue_ready),
    .done(done), .illegal(illegal), .mem(mem), .mem_rdata(mem_rdata), .irq(irq),
    .core_clk_stop(core_clk_stop), .regs(regs));
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    if (fails == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    ticks <= ticks + 1;
    if (ticks == 5000) begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [7:0] mem_at(input logic [15:0] a);
    if (a == VEC) return vec_hi;
    if (a == VEC + 16'h0001) return vec_lo;
    return rd_val;
  endfunction

  // V cleared, N and Z from the operand, every other flag kept
  function automatic logic [7:0] exp_test_flags(input logic [7:0] f, input logic [7:0] v);
    return {1'b0, f[6:3], v[7], v == 8'h00, f[0]};
  endfunction

  // Entered just after an edge with the unit idle; returns one cycle after done
  task automatic exec(input logic pfx, input logic [7:0] op, input logic [7:0] opd,
                      output int n);
    logic re_seen;
    n = 0;
    wq.delete();
    aq.delete();
    r0 = regs;
    issue_req = '{pfx, op, opd};
    issue_valid = 1'b1;
    @(posedge clock);
    #5;
    issue_valid = 1'b0;
    while (n < 20) begin
      @(negedge clock);
      n++;
      re_seen = mem.re;
      if (mem.re === 1'b1) rd_addr = mem.addr;
      if (mem.we === 1'b1) begin
        wq.push_back(mem.wdata);
        aq.push_back(mem.addr);
      end
      if (done === 1'b1) break;
      @(posedge clock);
      #5;
      // Unread cycles toggle the data so stale bytes never look valid
      mem_rdata = re_seen ? mem_at(rd_addr) : ~mem_rdata;
    end
    @(posedge clock);
    #5;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int n, k;
    logic [7:0] d, opd;
    logic [15:0] ea, p1;
    logic [7:0] pe[5];
    void'($urandom(24));
    repeat (20) @(posedge clock);
    #5;
    arst_n = 1'b1;
    repeat (3) @(posedge clock);
    #5;
    // Valid stays up across both refused offers, then drops with an edge to spare
    foreach (bad[j]) begin
      issue_req = bad[j];
      issue_valid = 1'b1;
      @(negedge clock);
      chk("illegal", 16'h0001, {15'h0000, illegal});
      @(posedge clock);
      #5;
    end
    issue_valid = 1'b0;
    @(posedge clock);
    #5;
    vec_hi = 8'($urandom);
    vec_lo = 8'($urandom);
    exec(1'b0, 8'h83, 8'h00, n);
    p1 = r0.pc + 16'h0001;
    pe = '{p1[7:0], p1[15:8], r0.hx[7:0], r0.a, r0.flags};
    chk("trap cycles", 16'h0009, 16'(n));
    chk("push count", 16'h0005, 16'(wq.size()));
    foreach (wq[i]) begin
      chk("push addr", r0.sp - 16'(i), aq[i]);
      chk("push data", pe[i], wq[i]);
    end
    chk("trap pc", {vec_hi, vec_lo}, regs.pc);
    chk("trap sp", r0.sp - 16'h0005, regs.sp);
    chk("trap flags", r0.flags | 8'h08, regs.flags);
    exec(1'b0, 8'h95, 8'h00, n);
    chk("s2i cycles", 16'h0002, 16'(n));
    chk("s2i", r0.sp + 16'h0001, regs.hx);
    exec(1'b0, 8'h94, 8'h00, n);
    chk("i2s cycles", 16'h0002, 16'(n));
    chk("i2s", r0.hx - 16'h0001, regs.sp);
    chk("i2s flags", r0.flags, regs.flags);
    for (int i = 0; i < 30; i++) begin
      k = (i < 6) ? i : int'($urandom_range(5));
      rd_val = (i < 6) ? {i[0], 7'h00} : 8'($urandom);
      opd = 8'($urandom);
      exec(k == 5, tops[k], opd, n);
      chk("test cycles", 16'(tcyc[k]), 16'(n));
      d = (k == 1) ? r0.a : (k == 2) ? r0.hx[7:0] : rd_val;
      chk("test flags", exp_test_flags(r0.flags, d), regs.flags);
      chk("test acc", r0.a, regs.a);
      ea = (k == 5) ? r0.sp + 16'(opd) : r0.hx + 16'((k == 3) ? opd : 8'h00);
      if (k == 0) ea = {8'h00, opd};
      if (k == 0 || k > 2) chk("test addr", ea, rd_addr);
    end
    exec(1'b0, 8'h8F, 8'h00, n);
    chk("wait cycles", 16'h0001, 16'(n));
    chk("wait flags", r0.flags & 8'hF7, regs.flags);
    repeat (5) @(posedge clock);
    #5;
    chk("sleep", 16'h0001, {issue_ready, core_clk_stop});
    irq = 1'b1;
    n = 0;
    while (issue_ready !== 1'b1 && n < 4) begin
      @(posedge clock);
      #5;
      n++;
    end
    irq = 1'b0;
    chk("wake", 16'h0002, {issue_ready, core_clk_stop});
    tally_and_finish();
  end
endmodule
